// File: verilog/pll_scan_defs.svh
// constants for the loop scan-chain reconfiguration block
`ifndef PLL_SCAN_DEFS_SVH
`define PLL_SCAN_DEFS_SVH

// chain geometry
`define CHAIN_BITS        144
`define SEG_COUNT         8
`define SEG_BITS          18
`define SHIFT_CNT_BITS    8

// shift clock ceiling, for reference by the controller side
`define SHIFT_CLK_MAX_MHZ 100

// register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_ACTIVE0       8'h10
`define REG_ACTIVE4       8'h20

// control fields and reset value
`define CTRL_APPLY_EN_BIT 0
`define CTRL_RESET        32'h0000_0001

// status fields
`define STAT_DONE_BIT     0
`define STAT_RSTREQ_BIT   1
`define STAT_SHIFT_BIT    2
`define STAT_CNT_LSB      8

`endif

// File: verilog/pll_scan_pkg.sv
// types shared by the scan-chain reconfiguration block
`include "pll_scan_defs.svh"
package pll_scan_pkg;

  // raw pins from the reconfiguration controller
  typedef struct packed {
    logic shift_clk;   // serial shift clock
    logic serial_in;   // serial settings data
    logic shift_en;    // shift enable
    logic apply;       // apply strobe
  } scan_link_t;

  // chain image as loaded or active
  typedef logic [`CHAIN_BITS-1:0] chain_image_t;

endpackage

// File: verilog/pll_counter_slice.sv
// one counter's setting, taken on that counter's own clock
`timescale 1ns/1ps
`include "pll_scan_defs.svh"
module pll_counter_slice
  import pll_scan_pkg::*;
#(
  parameter int SEG_W = `SEG_BITS
) (
  input  wire logic             core_clk_in,    // system clock
  input  wire logic             rst_n_in,       // synchronous reset, active low
  input  wire logic             cnt_clk_in,     // counter clock pin, async
  input  wire logic             load_in,        // new staged setting pulse
  input  wire logic [SEG_W-1:0] seg_in,         // staged setting
  output logic      [SEG_W-1:0] seg_out,        // active setting
  output logic                  pending_out     // setting waits for its edge
);

  logic       cnt_s1;      // first synchroniser stage
  logic       cnt_s2;      // second synchroniser stage
  logic       cnt_s3;      // edge history
  wire        cnt_rise = cnt_s2 & ~cnt_s3;   // counter clock rising edge

  ////////////////////////////////////////////////////////////////////////////
  // counter clock synchroniser
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
      cnt_s3 <= 1'b0;
    end else begin
      cnt_s1 <= cnt_clk_in;
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flag: a new load wins over the clear by an edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pending_out <= 1'b0;
    end else if (load_in) begin
      pending_out <= 1'b1;
    end else if (cnt_rise) begin
      pending_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active setting changes only on this counter's own edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      seg_out <= '0;
    end else if (pending_out && cnt_rise && !load_in) begin
      seg_out <= seg_in;
    end
  end

endmodule

// File: verilog/pll_scan_chain_reconfig.sv
// scan-chain reconfiguration of the loop counters, with a wishbone view
`timescale 1ns/1ps
`include "pll_scan_defs.svh"
module pll_scan_chain_reconfig
  import pll_scan_pkg::*;
#(
  parameter int NSEG  = `SEG_COUNT,
  parameter int SEG_W = `SEG_BITS
) (
  input  wire logic                  core_clk_in,        // system clock, 125 MHz
  input  wire logic                  rst_n_in,           // synchronous reset, active low
  input  wire scan_link_t            link_in,            // controller pins, async
  input  wire logic                  loop_areset_in,     // loop reset pin, async
  input  wire logic [NSEG-1:0]       cnt_clk_in,         // per-counter clocks, async
  output logic                       done_out,           // update in progress
  output logic                       reset_needed_out,   // loop reset still owed
  output logic [`CHAIN_BITS-1:0]     config_out,         // active configuration
  input  wire logic                  wb_cyc_i,           // wishbone cycle
  input  wire logic                  wb_stb_i,           // wishbone strobe
  input  wire logic                  wb_we_i,            // wishbone write
  input  wire logic [7:0]            wb_adr_i,           // wishbone byte address
  input  wire logic [3:0]            wb_sel_i,           // wishbone byte lanes
  input  wire logic [31:0]           wb_dat_i,           // wishbone write data
  output logic [31:0]                wb_dat_o,           // wishbone read data
  output logic                       wb_ack_o            // wishbone acknowledge
);

  ////////////////////////////////////////////////////////////////////////////
  // link synchronisers
  scan_link_t   link_s1;       // first stage, read only by the second
  scan_link_t   link_s2;       // second stage
  logic         clk_s3;        // shift clock history
  logic         rst_s1;        // loop reset first stage
  logic         rst_s2;        // loop reset second stage
  logic         rst_s3;        // loop reset history

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      link_s1 <= '0;
      link_s2 <= '0;
      clk_s3  <= 1'b0;
      rst_s1  <= 1'b0;
      rst_s2  <= 1'b0;
      rst_s3  <= 1'b0;
    end else begin
      link_s1 <= link_in;
      link_s2 <= link_s1;
      clk_s3  <= link_s2.shift_clk;
      rst_s1  <= loop_areset_in;
      rst_s2  <= rst_s1;
      rst_s3  <= rst_s2;
    end
  end

  wire shift_rise = link_s2.shift_clk & ~clk_s3;   // shift clock rising edge
  wire loop_rst_rise = rst_s2 & ~rst_s3;           // loop reset pulse seen

  ////////////////////////////////////////////////////////////////////////////
  // control register and its decode
  logic [31:0]  ctrl;                  // software control
  wire  apply_en = ctrl[`CTRL_APPLY_EN_BIT];
  wire  wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master samples ack high
  wire  wr_req   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire  hit_ctrl = (wb_adr_i == `REG_CTRL);
  wire  hit_stat = (wb_adr_i == `REG_STATUS);
  wire  hit_act  = (wb_adr_i >= `REG_ACTIVE0) && (wb_adr_i <= `REG_ACTIVE4)
                   && (wb_adr_i[1:0] == 2'b00);
  wire  clr_rstreq = wr_req & hit_stat & wb_sel_i[0] & wb_dat_i[`STAT_RSTREQ_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // shift state: arm on first edge after enable, shift on later edges
  chain_image_t                 chain;       // serial scan chain
  logic                         armed;       // first edge already passed
  logic [`SHIFT_CNT_BITS-1:0]   shift_cnt;   // bits taken this pass
  wire  do_shift = shift_rise & link_s2.shift_en & armed;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      armed <= 1'b0;
    end else if (!link_s2.shift_en) begin
      armed <= 1'b0;
    end else if (shift_rise) begin
      armed <= 1'b1;
    end
  end

  // chain moves only on a shift edge while enabled
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      chain <= '0;
    end else if (do_shift) begin
      chain <= {link_s2.serial_in, chain[`CHAIN_BITS-1:1]};
    end
  end

  // count of bits shifted since the enable rose, saturating
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      shift_cnt <= '0;
    end else if (!link_s2.shift_en) begin
      shift_cnt <= shift_cnt;        // kept for software after the pass
    end else if (shift_rise && !armed) begin
      shift_cnt <= '0;               // new pass starts
    end else if (do_shift && shift_cnt != '1) begin
      shift_cnt <= shift_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apply strobe: taken once per assertion at a shift clock edge
  logic          apply_seen;    // strobe already taken this assertion
  chain_image_t  staged;        // image waiting for counter edges
  wire  load = shift_rise & link_s2.apply & ~apply_seen & apply_en;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      apply_seen <= 1'b0;
    end else if (!link_s2.apply) begin
      apply_seen <= 1'b0;            // re-armed for the next pass
    end else if (shift_rise) begin
      apply_seen <= 1'b1;
    end
  end

  // staged image captured from the chain on the apply edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      staged <= '0;
    end else if (load) begin
      staged <= chain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one slice per counter, each taking its part on its own clock
  logic [NSEG-1:0]  pending;         // slices still waiting
  logic             load_d;          // load delayed to meet the staged image

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      load_d <= 1'b0;
    end else begin
      load_d <= load;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSEG; g++) begin : g_seg
      pll_counter_slice #(
        .SEG_W (SEG_W)
      ) u_slice (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .cnt_clk_in  (cnt_clk_in[g]),
        .load_in     (load_d),
        .seg_in      (staged[g*SEG_W +: SEG_W]),
        .seg_out     (config_out[g*SEG_W +: SEG_W]),
        .pending_out (pending[g])
      );
    end
  endgenerate

  // done stays high from the apply edge until every slice has taken its part
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= load | load_d | (|pending);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop reset owed after an apply, cleared by the reset pulse or software
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reset_needed_out <= 1'b0;
    end else if (load) begin
      reset_needed_out <= 1'b1;      // set wins over clear
    end else if (loop_rst_rise || clr_rstreq) begin
      reset_needed_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle
  wire [159:0]  act_pad  = {{(160-`CHAIN_BITS){1'b0}}, config_out};
  wire [2:0]    act_idx  = 3'(wb_adr_i[4:2] - 3'd4);
  wire [31:0]   act_word = act_pad[act_idx*32 +: 32];
  wire [31:0]   stat_word = {16'h0000, shift_cnt, 5'h00, armed,
                             reset_needed_out, done_out};
  wire [31:0]   rd_mux = hit_ctrl ? ctrl :
                         hit_stat ? stat_word :
                         hit_act  ? act_word : 32'h0000_0000;

  // control register with byte lanes
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_req && hit_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // ack and read data registered together
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// File: verif/pll_scan_chain_reconfig_checker.sv
// port assertions for the scan-chain reconfiguration block
`timescale 1ns/1ps
`include "pll_scan_defs.svh"
module pll_scan_checker
  import pll_scan_pkg::*;
#(parameter int NSEG = `SEG_COUNT, parameter int SEG_W = `SEG_BITS) (
  input wire logic                   core_clk_in,
  input wire logic                   rst_n_in,
  input wire scan_link_t             link_in,
  input wire logic                   loop_areset_in,
  input wire logic [NSEG-1:0]        cnt_clk_in,
  input wire logic                   done_out,
  input wire logic                   reset_needed_out,
  input wire logic [`CHAIN_BITS-1:0] config_out,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // a bus request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // the apply strobe was up a few cycles back
  sequence s_applied;
    $past(link_in.apply, 4);
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_cfg_quiet: assert property ($changed(config_out) |-> done_out || $past(done_out))
    else $error("configuration moved outside update");
  a_done_cause: assert property ($rose(done_out) |-> s_applied)
    else $error("update started without apply");
  a_flag_on_apply: assert property ($rose(done_out) |-> ##[0:2] reset_needed_out)
    else $error("loop reset request not raised");
  a_reset_values: assert property ($rose(rst_n_in) |-> !done_out && config_out == '0)
    else $error("outputs not cleared by reset");
endmodule
bind pll_scan_chain_reconfig pll_scan_checker #(.NSEG(NSEG), .SEG_W(SEG_W)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link_in(link_in),
  .loop_areset_in(loop_areset_in), .cnt_clk_in(cnt_clk_in), .done_out(done_out),
  .reset_needed_out(reset_needed_out), .config_out(config_out), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// File: verif/scan_ctrl_model.sv
// behavioural reconfiguration controller on the scan link
`timescale 1ns/1ps
`include "pll_scan_defs.svh"
module scan_ctrl_model
  import pll_scan_pkg::*;
(
  output scan_link_t              link_out,
  output logic                    areset_out,
  output logic [`SEG_COUNT-1:0]   cnt_clk_out
);
  logic [`SEG_COUNT-1:0] cnt_run;  // counters allowed to tick
  initial begin
    link_out = '0;
    areset_out = 1'b0;
    cnt_clk_out = '0;
    cnt_run = '1;
  end
  // each counter clock runs at its own rate
  for (genvar g = 0; g < `SEG_COUNT; g++) begin : g_cnt
    always #(21 + 6 * g) if (cnt_run[g]) cnt_clk_out[g] = ~cnt_clk_out[g];
  end
  // one shift clock period of 160 ns, idle low
  task automatic tick();
    #80 link_out.shift_clk = 1'b1;
    #80 link_out.shift_clk = 1'b0;
  endtask
  // shift extra filler bits, then the image with bit 0 leading
  task automatic send(input chain_image_t img, input int extra);
    #3 link_out.shift_en = 1'b1;
    tick();
    for (int i = 0; i < extra + `CHAIN_BITS; i++) begin
      link_out.serial_in = (i < extra) ? i[0] : img[i - extra];
      tick();
    end
    link_out.shift_en = 1'b0;
    link_out.serial_in = ~link_out.serial_in;
  endtask
  // apply strobe held over one rising shift edge
  task automatic apply_pulse();
    #3 link_out.apply = 1'b1;
    tick();
    link_out.apply = 1'b0;
  endtask
  // shift clock and data toggle while enable stays low
  task automatic noise(input int n);
    #3;
    repeat (n) begin
      link_out.serial_in = ~link_out.serial_in;
      tick();
    end
  endtask
  // loop reset pulse after an update
  task automatic loop_reset();
    #3 areset_out = 1'b1;
    #40 areset_out = 1'b0;
  endtask
endmodule

// File: verif/pll_scan_chain_reconfig_tb_top.sv
// self-checking bench for the scan-chain reconfiguration block
`timescale 1ns/1ps
module pll_scan_chain_reconfig_tb_top
  import pll_scan_pkg::*;
();
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, done, flag, ack;
  logic [7:0] adr = 8'h00, cnt_clk;
  logic [31:0] wdat = 32'h0, rdat;
  logic [143:0] cfg;
  scan_link_t link;
  logic areset;
  int err_count = 0, compares = 0;
  chain_image_t imgs [3] = '{{9{16'h1e2d}}, {9{16'hc3a5}}, {8{18'h2f0f1}}};
  always #4 core_clk_in = ~core_clk_in;
  scan_ctrl_model model (.link_out(link), .areset_out(areset), .cnt_clk_out(cnt_clk));
  pll_scan_chain_reconfig dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .link_in(link), .loop_areset_in(areset), .cnt_clk_in(cnt_clk), .done_out(done),
    .reset_needed_out(flag), .config_out(cfg), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [143:0] got, input logic [143:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic hang(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
    print_verdict();
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge core_clk_in);
    q = rdat;
    if (n == 20) hang("no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic wait_done(input bit rise);
    int n;
    for (n = 0; rise && n < 400 && done !== 1'b1; n++) @(posedge core_clk_in);
    if (n == 400) hang("done never rose");
    for (n = 0; n < 4000 && done !== 1'b0; n++) @(posedge core_clk_in);
    if (n == 4000) hang("done never fell");
  endtask
  task automatic apply_wait();
    fork
      model.apply_pulse();
      wait_done(1'b1);
    join
    @(posedge core_clk_in);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    cmp(144'(q), 144'h1, "control reset value");
    wb(1'b1, 8'h40, 32'hffff_ffff, q);
    wb(1'b0, 8'h40, 32'h0, q);
    cmp(144'(q), 144'h0, "unmapped read");
    $display("regs test done");
  endtask
  task automatic t_load();
    logic [31:0] q;
    for (int k = 0; k < 3; k++) begin
      model.send(imgs[k], 0);
      apply_wait();
      cmp(cfg, imgs[k], "loaded image");
      wb(1'b0, 8'h10, 32'h0, q);
      cmp(144'(q), 144'(imgs[k][31:0]), "active word 0");
      wb(1'b0, 8'h20, 32'h0, q);
      cmp(144'(q), 144'(imgs[k][143:128]), "active word 4");
      wb(1'b0, 8'h04, 32'h0, q);
      cmp(144'(q[15:0]), 144'h9002, "status after pass");
    end
    model.send(imgs[1], 7);
    apply_wait();
    cmp(cfg, imgs[1], "extra bits pushed out");
    model.noise(30);
    apply_wait();
    cmp(cfg, imgs[1], "chain held while disabled");
    wb(1'b0, 8'h04, 32'h0, q);
    cmp(144'(q[15:0]), 144'h9702, "count held while disabled");
    $display("load test done");
  endtask
  task automatic t_gate();
    logic [31:0] q;
    bit seen = 0;
    wb(1'b1, 8'h00, 32'h0, q);
    fork
      model.apply_pulse();
      repeat (60) begin
        @(posedge core_clk_in);
        seen |= (done !== 1'b0);
      end
    join
    cmp(144'(seen), 144'h0, "apply not gated");
    wb(1'b1, 8'h00, 32'h1, q);
    $display("gate test done");
  endtask
  task automatic t_slow();
    model.cnt_run[3] = 1'b0;
    model.send(imgs[2], 0);
    fork
      model.apply_pulse();
      repeat (80) @(posedge core_clk_in);
    join
    cmp(144'(done), 144'h1, "done before last counter");
    cmp(144'(cfg[71:54]), 144'(imgs[1][71:54]), "paused part moved");
    cmp(144'(cfg[17:0]), 144'(imgs[2][17:0]), "running part kept old");
    model.cnt_run[3] = 1'b1;
    wait_done(1'b0);
    cmp(cfg, imgs[2], "all parts after done");
    $display("counter test done");
  endtask
  task automatic t_clear();
    logic [31:0] q;
    cmp(144'(flag), 144'h1, "flag after apply");
    wb(1'b1, 8'h04, 32'h2, q);
    cmp(144'(flag), 144'h0, "software clear");
    apply_wait();
    cmp(144'(flag), 144'h1, "flag after second apply");
    model.loop_reset();
    repeat (6) @(posedge core_clk_in);
    cmp(144'(flag), 144'h0, "loop reset clear");
    $display("clear test done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    t_regs();
    t_load();
    t_gate();
    t_slow();
    t_clear();
    print_verdict();
  end
endmodule
